// ===== bcs_bridge_model.sv
// Behavioural three-phase power stage and motor seen from the gate pins.
`timescale 1ns/1ns
`default_nettype none

module bcs_bridge_model
  import bcs_pkg::*;
#(
  parameter logic [SENSE_W-1:0] RAIL_HI = 8'hf0,  // Divided level of a leg switched high.
  parameter logic [SENSE_W-1:0] RAIL_LO = 8'h10   // Divided level of a leg switched low.
)(
  input wire logic clk,
  input wire logic [2:0] low_on,
  input wire logic [2:0] top_n,
  input wire logic [SENSE_W-1:0] bemf_level,
  output logic [SENSE_W-1:0] leg1_level,
  output logic [SENSE_W-1:0] leg2_level,
  output logic [SENSE_W-1:0] leg3_level,
  output logic overlap_seen
);
  // ----------------------------------------
  // Phase levels
  // ----------------------------------------
  // A switched leg sits at its rail; an undriven leg shows the motor's back-EMF.
  // A shorted leg reads mid-rail, which no table state should ever produce.
  function automatic logic [SENSE_W-1:0] level_of(input logic lo, input logic tn);
    if (lo && !tn)
    begin
      level_of = 8'h80;
    end
    else if (lo)
    begin
      level_of = RAIL_LO;
    end
    else if (!tn)
    begin
      level_of = RAIL_HI;
    end
    else
    begin
      level_of = bemf_level;
    end
  endfunction : level_of

  // Sense levels follow the switches with no delay.
  always_comb
  begin
    leg1_level = level_of(low_on[0], top_n[0]);
    leg2_level = level_of(low_on[1], top_n[1]);
    leg3_level = level_of(low_on[2], top_n[2]);
  end

  // ----------------------------------------
  // Shoot-through monitor
  // ----------------------------------------
  // Sticky, because a one-cycle overlap is as destructive as a long one.
  initial overlap_seen = 1'b0;
  always @(posedge clk)
  begin
    if ((low_on & ~top_n) != 3'h0)
    begin
      overlap_seen <= 1'b1;
    end
  end
endmodule : bcs_bridge_model
`default_nettype wire

// ===== bcs_commutation_sequencer.sv
// Six-state commutation sequencer with current-limit blanking and back-EMF steering.
`timescale 1ns/1ns
`default_nettype none

// How it works
// [RQ1] Six states A to F form one cycle.
// [RQ2] Advance one state per commutation clock rise.
// [RQ3] States A to C gate and sample table.
// [RQ4] States D to F gate and sample table.
// [RQ5] State machine steers the sampler phase select.
// [RQ6] Sample only the leg with no gate on.
// [RQ7] Low-side gates are active high.
// [RQ8] High-side gates are active low.
// [RQ9] Trip forces low gates off, tops unchanged.
// [RQ10] Blanking lasts exactly the set off-time.
// [RQ11] Integrator keeps off-time within one PWM period; here blanking_time is loaded as given, with no integrator or limit.
// [RQ12] Export commutation clock as tachometer output.
// [RQ13] Top commutation rate is 0.05 x poles x rpm.
// [RQ14] Neutral is average of three phase samples.
// [RQ15] Sign of phase minus neutral steers charge.
// [RQ16] Reset enters align state R.
// [RQ17] After F wrap back to A.
// [RQ18] Synchronised trip; retrigger restarts off-time count.
// [RQ19] Registered gates never overlap on one leg.

module bcs_commutation_sequencer
  import bcs_pkg::*;
#(
  parameter int POLE_COUNT = 4,   // Magnetic poles of the motor.
  parameter int MAX_RPM = 3000    // Highest intended speed in rpm.
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic comm_clock_in,
  input wire logic align_release,
  input wire logic overcurrent_trip_in,
  input wire logic [BLANK_W-1:0] blanking_time,
  input wire logic [SENSE_W-1:0] leg1_sense_input,
  input wire logic [SENSE_W-1:0] leg2_sense_input,
  input wire logic [SENSE_W-1:0] leg3_sense_input,
  output logic leg1_low_gate,
  output logic leg2_low_gate,
  output logic leg3_low_gate,
  output logic leg1_top_gate,
  output logic leg2_top_gate,
  output logic leg3_top_gate,
  output logic [1:0] sense_select,
  output logic loop_control_node_up,
  output logic loop_control_node_down,
  output logic rotor_rate_out,
  output logic overspeed_out
);

  // ----------------------------------------------------------------
  // Derived speed limit
  // ----------------------------------------------------------------
  // Highest commutation rate in Hz, and the shortest legal period in clock cycles.
  localparam int MAX_COMM_HZ = (SPEED_LAW_NUM * POLE_COUNT * MAX_RPM) / SPEED_LAW_DEN;
  localparam logic [PERIOD_W-1:0] MIN_PERIOD_CYC = PERIOD_W'(CLK_HZ / MAX_COMM_HZ);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pins_level; // Filtered commutation clock (bit 0) and trip (bit 1).
  logic comm_prev_ff;     // Previous filtered commutation clock level.
  logic trip_prev_ff;     // Previous filtered trip level.
  logic comm_rise;        // One-cycle pulse on a commutation clock rise.
  logic trip_rise;        // One-cycle pulse on a new over-current trip.

  // Both inputs come from outside the clock domain, so both take the filtered chain.
  bcs_pin_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in({overcurrent_trip_in, comm_clock_in}),
    .level_out(pins_level)
  );

  // Edge memory for both filtered levels.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      comm_prev_ff <= 1'b0;
      trip_prev_ff <= 1'b0;
    end
    else
    begin
      comm_prev_ff <= pins_level[0];
      trip_prev_ff <= pins_level[1];
    end
  end

  assign comm_rise = pins_level[0] & ~comm_prev_ff; // see [RQ2]
  assign trip_rise = pins_level[1] & ~trip_prev_ff; // see [RQ18]

  // ----------------------------------------------------------------
  // Commutation state machine
  // ----------------------------------------------------------------
  bcs_state_t state_ff;  // Current drive state.
  bcs_state_t nxt_state; // Drive state after this clock rise.

  // The commutation clock is the only thing that moves the state; R holds until released.
  always_comb
  begin
    nxt_state = state_ff;
    if (comm_rise)
    begin
      case (state_ff)
        ST_R: nxt_state = align_release ? ST_A : ST_R;
        ST_A: nxt_state = ST_B;   // see [RQ1]
        ST_B: nxt_state = ST_C;
        ST_C: nxt_state = ST_D;
        ST_D: nxt_state = ST_E;
        ST_E: nxt_state = ST_F;
        ST_F: nxt_state = ST_A;   // see [RQ17]
        default: nxt_state = ST_R;
      endcase
    end
  end

  // Reset puts the rotor into the align position.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_ff <= ST_R; // see [RQ16]
    else
      state_ff <= nxt_state; // see [RQ2]
  end

  // ----------------------------------------------------------------
  // Current-limit one-shot
  // ----------------------------------------------------------------
  logic [BLANK_W-1:0] blank_cnt_ff; // Off-time cycles still to run.
  logic blank_active;               // Low-side gates held off while set.

  // A trip loads the off-time; a later trip reloads it, so blanking restarts.
  // The count is sampled at the trip, so changing blanking_time mid-blank has no effect.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      blank_cnt_ff <= '0;
    else if (trip_rise)
      blank_cnt_ff <= blanking_time; // see [RQ18]
    else if (blank_cnt_ff != '0)
      blank_cnt_ff <= blank_cnt_ff - 1'b1; // see [RQ10]
  end

  assign blank_active = blank_cnt_ff != '0;

  // Measurement for the off-time check: blanked cycles since the last trip and
  // the off-time captured at that trip. It is kept apart from the one-shot so that
  // a miscount in the one-shot cannot hide itself.
  logic [BLANK_W-1:0] blank_len_ff; // Blanked cycles since the last trip.
  logic [BLANK_W-1:0] blank_set_ff; // Off-time loaded by the last trip.

  // A trip restarts the measurement; every blanked cycle after it is counted.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      blank_len_ff <= '0;
      blank_set_ff <= '0;
    end
    else if (trip_rise)
    begin
      blank_len_ff <= '0;
      blank_set_ff <= blanking_time;
    end
    else if (blank_active)
      blank_len_ff <= blank_len_ff + 1'b1;
  end

  // ----------------------------------------------------------------
  // Gate and sampler registers
  // ----------------------------------------------------------------
  logic [2:0] low_ff;   // Low-side gates, active high.
  logic [2:0] top_n_ff; // High-side gates, active low.
  logic [1:0] sel_ff;   // Sampler phase select.

  // All six gates update on one edge from one state value, so a leg never sees
  // both of its switches on, even while the state changes.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      low_ff <= GATES_OFF;
      top_n_ff <= TOPS_OFF;
      sel_ff <= SEL_NONE;
    end
    else
    begin
      low_ff <= bcs_low_of(state_ff) & {3{~blank_active}}; // see [RQ3] see [RQ4] see [RQ7] see [RQ9]
      top_n_ff <= ~bcs_top_of(state_ff); // see [RQ8] see [RQ19]
      sel_ff <= bcs_sel_of(state_ff); // see [RQ5] see [RQ6]
    end
  end

  assign leg1_low_gate = low_ff[0];
  assign leg2_low_gate = low_ff[1];
  assign leg3_low_gate = low_ff[2];
  assign leg1_top_gate = top_n_ff[0];
  assign leg2_top_gate = top_n_ff[1];
  assign leg3_top_gate = top_n_ff[2];
  assign sense_select = sel_ff;

  // ----------------------------------------------------------------
  // Back-EMF sampler
  // ----------------------------------------------------------------
  logic [SENSE_W+1:0] phase_sum;   // Sum of the three phase samples.
  logic [SENSE_W+1:0] sel_times3;  // Observed phase times three.
  logic [SENSE_W-1:0] sel_sample;  // Observed phase sample.
  logic up_ff;                     // Charge request.
  logic down_ff;                   // Discharge request.

  // Comparing 3 x phase with the sum is the same as phase against the average,
  // and avoids a divider.
  assign phase_sum = {2'b00, leg1_sense_input} + {2'b00, leg2_sense_input}
                   + {2'b00, leg3_sense_input}; // see [RQ14]

  // Mux the observed phase from the registered select.
  always_comb
  begin
    case (sel_ff)
      SEL_LEG1: sel_sample = leg1_sense_input;
      SEL_LEG2: sel_sample = leg2_sense_input;
      SEL_LEG3: sel_sample = leg3_sense_input;
      default: sel_sample = '0;
    endcase
  end

  assign sel_times3 = {2'b00, sel_sample} + {1'b0, sel_sample, 1'b0};

  // Above neutral charges the loop node, below discharges; equal or align does neither.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      up_ff <= 1'b0;
      down_ff <= 1'b0;
    end
    else
    begin
      up_ff <= (sel_ff != SEL_NONE) && (sel_times3 > phase_sum); // see [RQ15]
      down_ff <= (sel_ff != SEL_NONE) && (sel_times3 < phase_sum); // see [RQ15]
    end
  end

  assign loop_control_node_up = up_ff;
  assign loop_control_node_down = down_ff;

  // ----------------------------------------------------------------
  // Tachometer and speed check
  // ----------------------------------------------------------------
  logic tach_ff;                    // Exported commutation clock.
  logic [PERIOD_W-1:0] period_ff;   // Cycles since the last commutation rise.
  logic overspeed_ff;               // Last period was shorter than the limit.

  // The tachometer is the filtered commutation clock, one cycle late.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      tach_ff <= 1'b0;
    else
      tach_ff <= pins_level[0]; // see [RQ12]
  end

  // Period counter saturates so a stopped motor never wraps into a false alarm.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      period_ff <= '0;
    else if (comm_rise)
      period_ff <= '0;
    else if (period_ff != '1)
      period_ff <= period_ff + 1'b1;
  end

  // Flag each period faster than the top rate; the first period after reset counts too.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      overspeed_ff <= 1'b0;
    else if (comm_rise)
      overspeed_ff <= period_ff < (MIN_PERIOD_CYC - PERIOD_W'(1)); // see [RQ13]
  end

  assign rotor_rate_out = tach_ff;
  assign overspeed_out = overspeed_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_ONE_LOW: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ1]
    $countones(low_ff) <= 1) else $error("more than one low gate on");
  AST_NO_SHOOT: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ19]
    (low_ff & ~top_n_ff) == 3'h0) else $error("both switches of one leg on");
  AST_RESET_R: assert property (@(posedge clk) // see [RQ16]
    sys_rst ##1 !sys_rst |-> state_ff == ST_R ##1 (top_n_ff == 3'h2 && sel_ff == SEL_NONE))
    else $error("reset did not enter align");
  AST_ADVANCE: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ2]
    comm_rise && state_ff != ST_R |=> state_ff != $past(state_ff))
    else $error("state did not advance");
  AST_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ2]
    !comm_rise |=> $stable(state_ff)) else $error("state moved without clock");
  AST_WRAP: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ17]
    comm_rise && state_ff == ST_F |=> state_ff == ST_A) else $error("no wrap to A");
  AST_SAMPLE_IDLE: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ6]
    sel_ff != SEL_NONE |-> !low_ff[sel_ff - 2'h1] && top_n_ff[sel_ff - 2'h1])
    else $error("sampled leg is driven");
  AST_BLANK_ON: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ9]
    trip_rise && blanking_time != '0 |=> ##1 low_ff == 3'h0)
    else $error("low gates not blanked");
  AST_TOP_FOLLOW: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ9]
    blank_active |=> top_n_ff == ~bcs_top_of($past(state_ff)))
    else $error("top gates disturbed by blanking");
  AST_BLANK_LEN: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ10]
    $fell(blank_active) |-> blank_len_ff == blank_set_ff)
    else $error("off-time length wrong");
  AST_TACH: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ12]
    comm_rise |=> rotor_rate_out ##1 $rose(rotor_rate_out) == 1'b0)
    else $error("tachometer does not follow clock");
  AST_CHARGE: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ15]
    sel_ff != SEL_NONE && sel_times3 > phase_sum |=> up_ff && !down_ff)
    else $error("charge direction wrong");

  COV_FULL_CYCLE: cover property (@(posedge clk) disable iff (sys_rst)
    state_ff == ST_F && comm_rise ##1 state_ff == ST_A);
  COV_RETRIGGER: cover property (@(posedge clk) disable iff (sys_rst)
    blank_active && trip_rise);
  COV_LEAVE_ALIGN: cover property (@(posedge clk) disable iff (sys_rst)
    state_ff == ST_R ##1 state_ff == ST_A);
  COV_OVERSPEED: cover property (@(posedge clk) disable iff (sys_rst) $rose(overspeed_ff));

endmodule : bcs_commutation_sequencer

`default_nettype wire

// ===== bcs_pin_sync.sv
// Three-stage pin synchroniser with an agreement filter, one lane per bit.
`timescale 1ns/1ns
`default_nettype none

module bcs_pin_sync
  import bcs_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  // ----------------------------------------------------------------
  // One lane per bit
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_lane
      logic meta_ff;    // First stage, read only by the second stage.
      logic stage2_ff;  // Second stage.
      logic stage3_ff;  // Third stage.
      logic level_ff;   // Filtered level.

      // Shift chain; the first stage may go metastable, so nothing else looks at it.
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          meta_ff <= 1'b0;
          stage2_ff <= 1'b0;
          stage3_ff <= 1'b0;
        end
        else
        begin
          meta_ff <= pin_in[gi];
          stage2_ff <= meta_ff;
          stage3_ff <= stage2_ff;
        end
      end

      // A change is accepted only once stages two and three agree.
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          level_ff <= 1'b0;
        else if (stage2_ff == stage3_ff)
          level_ff <= stage3_ff;
      end

      assign level_out[gi] = level_ff;
    end
  endgenerate

endmodule : bcs_pin_sync

`default_nettype wire

// ===== bcs_pkg.sv
// Shared constants, state type and drive tables for the commutation sequencer.
package bcs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50000000;     // System clock rate in Hz.
  localparam int CLK_PERIOD_NS = 20;    // System clock period in ns.
  // The speed law is f = 0.05 * poles * rpm, kept as a ratio of integers.
  localparam int SPEED_LAW_NUM = 5;     // Numerator of the 0.05 Hz/rpm factor.
  localparam int SPEED_LAW_DEN = 100;   // Denominator of the 0.05 Hz/rpm factor.

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int SENSE_W = 8;           // Width of one digitised phase sample.
  localparam int BLANK_W = 16;          // Width of the off-time count.
  localparam int PERIOD_W = 24;         // Width of the commutation period counter.
  localparam logic [2:0] GATES_OFF = 3'h0;  // Reset value for the low-side gate group.
  localparam logic [2:0] TOPS_OFF = 3'h7;   // Reset value for the active-low top group.
  localparam logic [1:0] SEL_NONE = 2'h0;   // Sampler select: no phase observed.
  localparam logic [1:0] SEL_LEG1 = 2'h1;   // Sampler select: leg 1 observed.
  localparam logic [1:0] SEL_LEG2 = 2'h2;   // Sampler select: leg 2 observed.
  localparam logic [1:0] SEL_LEG3 = 2'h3;   // Sampler select: leg 3 observed.

  // ----------------------------------------------------------------
  // Commutation states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_R, ST_A, ST_B, ST_C, ST_D, ST_E, ST_F} bcs_state_t;

  // Low-side gates switched on in a state; bit 0 is leg 1.
  function automatic logic [2:0] bcs_low_of(input bcs_state_t s);
    case (s)
      ST_R: bcs_low_of = 3'h2;
      ST_A: bcs_low_of = 3'h4;
      ST_B: bcs_low_of = 3'h4;
      ST_C: bcs_low_of = 3'h1;
      ST_D: bcs_low_of = 3'h1;
      ST_E: bcs_low_of = 3'h2;
      ST_F: bcs_low_of = 3'h2;
      default: bcs_low_of = 3'h0;
    endcase
  endfunction : bcs_low_of

  // High-side switches turned on in a state (active high here); bit 0 is leg 1.
  function automatic logic [2:0] bcs_top_of(input bcs_state_t s);
    case (s)
      ST_R: bcs_top_of = 3'h5;
      ST_A: bcs_top_of = 3'h1;
      ST_B: bcs_top_of = 3'h2;
      ST_C: bcs_top_of = 3'h2;
      ST_D: bcs_top_of = 3'h4;
      ST_E: bcs_top_of = 3'h4;
      ST_F: bcs_top_of = 3'h1;
      default: bcs_top_of = 3'h0;
    endcase
  endfunction : bcs_top_of

  // Leg the sampler observes in a state: the one with neither switch on.
  function automatic logic [1:0] bcs_sel_of(input bcs_state_t s);
    case (s)
      ST_A: bcs_sel_of = SEL_LEG2;
      ST_B: bcs_sel_of = SEL_LEG1;
      ST_C: bcs_sel_of = SEL_LEG3;
      ST_D: bcs_sel_of = SEL_LEG2;
      ST_E: bcs_sel_of = SEL_LEG1;
      ST_F: bcs_sel_of = SEL_LEG3;
      default: bcs_sel_of = SEL_NONE;
    endcase
  endfunction : bcs_sel_of

endpackage : bcs_pkg

// ===== tb.sv
// Self-checking testbench for the commutation sequencer.
`timescale 1ns/1ns
`default_nettype none

module tb;
  import bcs_pkg::*;
  localparam logic [7:0] HI = 8'hf0;  // Level of a leg switched high.
  localparam logic [7:0] LO = 8'h10;  // Level of a leg switched low.
  localparam logic [15:0] OFF_N = 16'h000a;  // Off-time, well inside one PWM period
  // Expected low gates, top switches on and sampled leg for R, A to F.
  localparam logic [2:0] EXP_LOW [7] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2, 3'h2};
  localparam logic [2:0] EXP_TOP [7] = '{3'h5, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h1};
  localparam logic [1:0] EXP_SEL [7] = '{2'h0, 2'h2, 2'h1, 2'h3, 2'h2, 2'h1, 2'h3};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic comm_pin = 1'b0;
  logic align_go = 1'b0;
  logic trip_pin = 1'b0;
  logic [SENSE_W-1:0] bemf = 8'h40;
  logic [SENSE_W-1:0] s1, s2, s3;
  logic lo1, lo2, lo3, tp1, tp2, tp3, up, dn, tach, fast, overlap;
  logic [1:0] sel;
  int n_fail = 0;
  int n_compared = 0;

  // Free-running 50 MHz system clock.
  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  bcs_commutation_sequencer DUT (
    .clk(clk), .sys_rst(sys_rst), .comm_clock_in(comm_pin), .align_release(align_go),
    .overcurrent_trip_in(trip_pin), .blanking_time(OFF_N), .leg1_sense_input(s1),
    .leg2_sense_input(s2), .leg3_sense_input(s3), .leg1_low_gate(lo1), .leg2_low_gate(lo2),
    .leg3_low_gate(lo3), .leg1_top_gate(tp1), .leg2_top_gate(tp2), .leg3_top_gate(tp3),
    .sense_select(sel), .loop_control_node_up(up), .loop_control_node_down(dn),
    .rotor_rate_out(tach), .overspeed_out(fast)
  );

  bcs_bridge_model #(.RAIL_HI(HI), .RAIL_LO(LO)) bridge (
    .clk(clk), .low_on({lo3, lo2, lo1}), .top_n({tp3, tp2, tp1}), .bemf_level(bemf),
    .leg1_level(s1), .leg2_level(s2), .leg3_level(s3), .overlap_seen(overlap)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compares one value and counts it.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Advances n falling edges, where all inputs change.
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // One commutation clock period, long enough for the pin filter.
  task automatic comm_step();
    comm_pin = 1'b1;
    tick(8);
    check("tach_high", tach, 1'b1);
    comm_pin = 1'b0;
    tick(8);
    check("tach_low", tach, 1'b0);
  endtask : comm_step

  // Gates, sampled leg and charge direction for state index i.
  task automatic check_state(input int i);
    logic exp_up;
    logic exp_dn;
    exp_up = (i != 0) && (3 * int'(bemf) > int'(HI) + int'(LO) + int'(bemf));
    exp_dn = (i != 0) && (3 * int'(bemf) < int'(HI) + int'(LO) + int'(bemf));
    check("low_gates", {lo3, lo2, lo1}, EXP_LOW[i]);
    check("top_gates", {tp3, tp2, tp1}, {5'h00, ~EXP_TOP[i]});
    check("sense_select", sel, EXP_SEL[i]);
    check("charge_up", up, exp_up);
    check("charge_down", dn, exp_dn);
  endtask : check_state

  // Ticks from a trip pin rise until lows go dark, and until they return.
  task automatic blank_span(output int to_zero, output int to_back);
    to_zero = 0;
    to_back = 0;
    while (({lo3, lo2, lo1} !== 3'h0) && (to_zero < 30))
    begin
      tick(1);
      to_zero++;
    end
    check("tops_in_blank", {tp3, tp2, tp1}, {5'h00, ~EXP_TOP[1]});
    to_back = to_zero;
    while (({lo3, lo2, lo1} === 3'h0) && (to_back < 60))
    begin
      tick(1);
      to_back++;
    end
  endtask : blank_span

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset forces all gates off, then the align state follows.
  task automatic t_reset();
    tick(2);
    check("rst_lows", {lo3, lo2, lo1}, 3'h0);
    check("rst_tops", {tp3, tp2, tp1}, 3'h7);
    sys_rst = 1'b0;
    tick(3);
    check_state(0);
  endtask : t_reset

  // Without release the align state ignores the commutation clock.
  task automatic t_align_hold();
    comm_step();
    check_state(0);
  endtask : t_align_hold

  // Two full cycles and a bit, with back-EMF above and below neutral.
  task automatic t_cycle();
    align_go = 1'b1;
    for (int i = 1; i <= 13; i++)
    begin
      bemf = i[0] ? 8'hc0 : 8'h40;
      comm_step();
      check_state(((i - 1) % 6) + 1);
    end
    check("overspeed", fast, 1'b1);
  endtask : t_cycle

  // Trip held high blanks exactly once; a retrigger restarts the count.
  task automatic t_trip();
    int z1;
    int b1;
    int z2;
    int b2;
    trip_pin = 1'b1;
    blank_span(z1, b1);
    check("blank_len", 8'(b1 - z1), OFF_N[7:0]);
    // The charge outputs are registered from the sense levels one clock later.
    tick(2);
    check_state(1);
    trip_pin = 1'b0;
    tick(5);
    // Second rise comes after the first blanking ends; the third lands while the second still runs.
    trip_pin = 1'b1;
    tick(5);
    trip_pin = 1'b0;
    tick(4);
    trip_pin = 1'b1;
    blank_span(z2, b2);
    check("retrig_held", 8'(z2), 8'h00);
    check("retrig_len", 8'(b2), 8'(z1 + int'(OFF_N)));
    trip_pin = 1'b0;
    check("overlap", overlap, 1'b0);
  endtask : t_trip

  // ----------------------------------------
  // Verdict and run control
  // ----------------------------------------
  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (n_fail == 0 && n_compared > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // The tests take well under a thousand cycles; this cuts off any hang.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end

  // Main sequence.
  initial
  begin
    t_reset();
    t_align_hold();
    t_cycle();
    t_trip();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
